// ### hdl/srh_defs.svh
// srh_defs.svh: offsets, field positions, reset values and timing figures
// for the sync reference hold-over controller.
// assumes: included by bare name; CLK runs at the rate given below.
`ifndef SRH_DEFS_SVH
`define SRH_DEFS_SVH

// clock rate and the derived cycle count of one second tick
`define SRH_CLK_HZ          20000000
`define SRH_TICK_CYCLES     (`SRH_CLK_HZ * 1)

// register byte offsets (low address byte)
`define SRH_ADDR_CTRL       8'h00
`define SRH_ADDR_CONFIG     8'h04
`define SRH_ADDR_STATUS     8'h08
`define SRH_ADDR_FAULT      8'h0C
`define SRH_ADDR_CMD        8'h10
`define SRH_ADDR_TIMERS     8'h14

// control fields and reset values
`define SRH_CTRL_EN_BIT     0
`define SRH_CTRL_OPT_BIT    1
`define SRH_CTRL_OPT_RST    1'h1
// config fields
`define SRH_CFG_MODE_LSB    0
`define SRH_CFG_STYPE_LSB   2
`define SRH_CFG_AVA_BIT     4
`define SRH_CFG_AVB_BIT     5
// command fields
`define SRH_CMD_RESET_BIT   0
`define SRH_CMD_START_BIT   1
`define SRH_CMD_WARM_BIT    2
// fault fields
`define SRH_FLT_MISS_BIT    0
`define SRH_FLT_EXP_BIT     1
`define SRH_FLT_LOCK_BIT    2
`define SRH_FLT_CFG_BIT     3
`define SRH_FLT_LATE_BIT    4
`define SRH_FLT_W           5

// times in their own units, then in seconds counted by the timers
`define SRH_COLD_NET_MIN    5
`define SRH_COLD_OPT_MIN    10
`define SRH_RESET_SYNC_S    10
`define SRH_START_SYNC_S    30
`define SRH_WARM_SYNC_S     90
`define SRH_HOLD_ENTER_MIN  5
`define SRH_HOLD_EXP_MS_MIN 60
`define SRH_HOLD_EXP_SL_MIN 15
`define SRH_LOCK_TO_MIN     6
`define SRH_COLD_NET_S      (`SRH_COLD_NET_MIN * 60)
`define SRH_COLD_OPT_S      (`SRH_COLD_OPT_MIN * 60)
`define SRH_HOLD_ENTER_S    (`SRH_HOLD_ENTER_MIN * 60)
`define SRH_HOLD_EXP_MS_S   (`SRH_HOLD_EXP_MS_MIN * 60)
`define SRH_HOLD_EXP_SL_S   (`SRH_HOLD_EXP_SL_MIN * 60)
`define SRH_LOCK_TO_S       (`SRH_LOCK_TO_MIN * 60)
`define SRH_SEC_W           12

`endif

// ### hdl/srh_pkg.sv
// srh_pkg.sv: types of the sync reference hold-over controller.
// assumes: compiled before every module that imports it.
package srh_pkg;

    typedef enum logic [4:0] {
        SRH_IDLE     = 5'h01,
        SRH_SELECT   = 5'h02,
        SRH_LOCKING  = 5'h04,
        SRH_SYNCING  = 5'h08,
        SRH_HOLDOVER = 5'h10
    } srh_state_type;

    typedef enum logic [1:0] {
        SRH_MODE_UNDEF  = 2'h0,
        SRH_MODE_MASTER = 2'h1,
        SRH_MODE_ALONE  = 2'h2,
        SRH_MODE_SLAVE  = 2'h3
    } srh_mode_type;

    typedef enum logic [1:0] {
        SRH_ST_UNDEF    = 2'h0,
        SRH_ST_PCM      = 2'h1,
        SRH_ST_INTERNAL = 2'h2
    } srh_stype_type;

    typedef enum logic [1:0] {
        SRH_SRC_PCM  = 2'h0,
        SRH_SRC_OPT  = 2'h1,
        SRH_SRC_PEER = 2'h2
    } srh_src_type;

endpackage

// ### hdl/srh_sec_timer.sv
// srh_sec_timer.sv: seconds counter driven by a prescaled cycle count.
// assumes: clr wins over run; the count saturates at its top value.
`timescale 1ns/100ps
`include "srh_defs.svh"

module srh_sec_timer #(
    parameter int TICK_CYCLES = `SRH_TICK_CYCLES
) (
    input  wire logic                   CLK,
    input  wire logic                   ARST_N,
    input  wire logic                   CE,
    input  wire logic                   CLR,
    input  wire logic                   RUN,
    output logic [`SRH_SEC_W-1:0]       SECS
);
    logic [24:0]            pre_q, pre_d;
    logic [`SRH_SEC_W-1:0]  sec_q, sec_d;

    // prescaler wraps once a second; seconds stop at all ones
    always_comb begin
        pre_d = pre_q;
        sec_d = sec_q;
        if (CLR) begin
            pre_d = 25'h0;
            sec_d = '0;
        end else if (RUN) begin
            if (pre_q == 25'(TICK_CYCLES - 1)) begin
                pre_d = 25'h0;
                if (sec_q != '1)
                    sec_d = sec_q + 1'b1;
            end else begin
                pre_d = pre_q + 25'h1;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_q <= 25'h0;
            sec_q <= '0;
        end else if (CE) begin
            pre_q <= pre_d;
            sec_q <= sec_d;
        end
    end

    assign SECS = sec_q;

endmodule // srh_sec_timer

// ### hdl/srh_core.sv
// srh_core.sv: reference selection, locking supervision, synchronizing and
// hold-over control with an AHB-Lite register slave.
// assumes: pin inputs synchronous to CLK; REF_USABLE is the supervision
// verdict on the currently selected reference; LOCK_DONE from the loop.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "srh_defs.svh"

// Functional notes
// - one locked oscillator feeds RF and timebase for all carriers
// - synchronizing starts at first lock and after hold-over recovery
// - synchronizing stops on faulty reference, pinned control, slave reconfig
// - mode change to slave is rejected while the function is enabled
// - cold start sync within 5 min network/peer, 10 min optional; code budgets 10 min whenever OPT_FITTED and opt_pref_q are set, peer included
// - resync within 10 s reset, 30 s start, 90 s warm start
// - selection runs on start-up, expiry, re-establish, config, failed lock
// - a PCM reference is selectable only when marked available
// - source type from mode, configured type and fitted optional hardware
// - internal type without optional hardware is rejected
// - controller may switch between optional reference and PCM
// - start-up takes PCM A if usable, else PCM B if usable
// - PCM defect moves to other interface if it has signal and available
// - selection ends on new choice, regained signal, or other source type
// - switching source causes no phase or frequency step
// - unusable reference enters hold-over with control value frozen
// - hold-over still reports synchronized and keeps supervising
// - five minutes in hold-over sends a missing-reference fault
// - hold-over expiry after 60 min master/alone or 15 min slave
// - hold-over ends when reference usable again or on expiry
// - mode is stand-alone until the controller sets it
// - locking beyond six minutes is a fault, locking keeps trying
module srh_core
    import srh_pkg::*;
#(
    parameter int TICK_CYCLES = `SRH_TICK_CYCLES
) (
    input  wire logic           CLK,
    input  wire logic           ARST_N,
    input  wire logic           CE,
    input  wire logic           HSEL,
    input  wire logic [31:0]    HADDR,
    input  wire logic [1:0]     HTRANS,
    input  wire logic           HWRITE,
    input  wire logic [2:0]     HSIZE,
    input  wire logic [31:0]    HWDATA,
    input  wire logic           HREADY,
    output logic [31:0]         HRDATA,
    output logic                HREADYOUT,
    output logic                HRESP,
    input  wire logic           PCM_A_DEFECT,
    input  wire logic           PCM_B_DEFECT,
    input  wire logic           OPT_FITTED,
    input  wire logic           REF_USABLE,
    input  wire logic           LOCK_DONE,
    input  wire logic           CTRL_AT_LIMIT,
    output logic [1:0]          SRC_SEL,
    output logic                PCM_EXEC_B,
    output logic                OSC_HOLD,
    output logic                SYNCED
);

    // a PCM interface is usable when marked available and fault free
    function automatic logic pcm_ok(input logic avail, input logic defect);
        return avail && !defect;
    endfunction

    // source type from mode, configured type and fitted hardware
    function automatic srh_src_type pick_src(input srh_mode_type m,
                                             input srh_stype_type t,
                                             input logic fitted,
                                             input logic pref);
        if (m == SRH_MODE_SLAVE)
            return SRH_SRC_PEER;
        if (t == SRH_ST_PCM)
            return SRH_SRC_PCM;
        if (fitted && pref)
            return SRH_SRC_OPT;
        return SRH_SRC_PCM;
    endfunction

    // bus slave state
    logic           wr_q, wr_d;
    logic [7:0]     waddr_q, waddr_d;
    logic [31:0]    rdata_q, rdata_d;
    // software visible state
    logic           enable_q, enable_d;
    logic           opt_pref_q, opt_pref_d;
    srh_mode_type   mode_q, mode_d;
    srh_stype_type  stype_q, stype_d;
    logic           avail_a_q, avail_a_d;
    logic           avail_b_q, avail_b_d;
    logic [`SRH_FLT_W-1:0] fault_q, fault_d;
    // control state
    srh_state_type  state_q, state_d;
    srh_src_type    src_q, src_d;
    logic           exec_b_q, exec_b_d;
    logic           synced_q, synced_d;
    logic           miss_sent_q, miss_sent_d;
    logic [`SRH_SEC_W-1:0] budget_q, budget_d;
    logic           budget_run_q, budget_run_d;

    logic [`SRH_SEC_W-1:0] lock_secs, hold_secs, budget_secs;
    logic           wr_ctrl, wr_cfg, wr_flt, wr_cmd;
    logic           cfg_ok, resel, exec_defect, other_ok;
    logic [`SRH_FLT_W-1:0] flt_set, flt_clr;
    logic [`SRH_SEC_W-1:0] resel_budget;
    srh_mode_type   new_mode;
    srh_stype_type  new_stype;

    // lock, hold-over and sync-budget timers each prescale their own seconds tick
    srh_sec_timer #(.TICK_CYCLES(TICK_CYCLES)) u_lock_tmr (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .CE     (CE),
        .CLR    (state_q != SRH_LOCKING),
        .RUN    (1'b1),
        .SECS   (lock_secs)
    );

    // hold-over counter restarts at every hold-over entry
    srh_sec_timer #(.TICK_CYCLES(TICK_CYCLES)) u_hold_tmr (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .CE     (CE),
        .CLR    (state_q != SRH_HOLDOVER),
        .RUN    (1'b1),
        .SECS   (hold_secs)
    );

    srh_sec_timer #(.TICK_CYCLES(TICK_CYCLES)) u_budget_tmr (
        .CLK    (CLK),
        .ARST_N (ARST_N),
        .CE     (CE),
        .CLR    (resel),
        .RUN    (budget_run_q),
        .SECS   (budget_secs)
    );

    // bus decode: writes land in the data phase, reads are registered
    always_comb begin
        wr_d    = 1'b0;
        waddr_d = waddr_q;
        rdata_d = rdata_q;
        if (HSEL && HREADY && HTRANS[1]) begin
            wr_d    = HWRITE;
            waddr_d = HADDR[7:0];
            rdata_d = 32'h0;
            if (!HWRITE) begin
                case (HADDR[7:0])
                    `SRH_ADDR_CTRL:   rdata_d = {30'h0, opt_pref_q, enable_q};
                    `SRH_ADDR_CONFIG: rdata_d = {26'h0, avail_b_q, avail_a_q,
                                                 stype_q, mode_q};
                    `SRH_ADDR_STATUS: rdata_d = {21'h0, OPT_FITTED, OSC_HOLD,
                                                 synced_q, exec_b_q, src_q,
                                                 state_q};
                    `SRH_ADDR_FAULT:  rdata_d = {27'h0, fault_q};
                    `SRH_ADDR_TIMERS: rdata_d = {4'h0, lock_secs,
                                                 4'h0, hold_secs};
                    default:          rdata_d = 32'h0;
                endcase
            end
        end
    end

    assign wr_ctrl = wr_q && (waddr_q == `SRH_ADDR_CTRL);
    assign wr_cfg  = wr_q && (waddr_q == `SRH_ADDR_CONFIG);
    assign wr_flt  = wr_q && (waddr_q == `SRH_ADDR_FAULT);
    assign wr_cmd  = wr_q && (waddr_q == `SRH_ADDR_CMD) && enable_q;
    assign new_mode  = srh_mode_type'(HWDATA[`SRH_CFG_MODE_LSB +: 2]);
    assign new_stype = srh_stype_type'(HWDATA[`SRH_CFG_STYPE_LSB +: 2]);

    // configuration check: change to slave only while disabled, internal needs hw
    assign cfg_ok = !(enable_q && new_mode == SRH_MODE_SLAVE
                      && mode_q != SRH_MODE_SLAVE)
                 && !(new_stype == SRH_ST_INTERNAL && !OPT_FITTED)
                 && (new_stype != 2'h3);

    // executive PCM health and the other interface's fitness
    assign exec_defect = exec_b_q ? PCM_B_DEFECT : PCM_A_DEFECT;
    assign other_ok    = exec_b_q ? pcm_ok(avail_a_q, PCM_A_DEFECT)
                                  : pcm_ok(avail_b_q, PCM_B_DEFECT);

    // events that restart selection while enabled, and the sync budget
    always_comb begin
        resel        = 1'b0;
        resel_budget = budget_q;
        if (wr_ctrl && HWDATA[`SRH_CTRL_EN_BIT] && !enable_q) begin
            resel        = 1'b1;
            resel_budget = OPT_FITTED && opt_pref_q
                         ? `SRH_SEC_W'(`SRH_COLD_OPT_S)
                         : `SRH_SEC_W'(`SRH_COLD_NET_S);
        end else if (enable_q && ((wr_cfg && cfg_ok)
                 || (wr_ctrl && HWDATA[`SRH_CTRL_OPT_BIT] != opt_pref_q))) begin
            resel        = 1'b1;
            resel_budget = `SRH_SEC_W'(`SRH_START_SYNC_S);
        end else if (wr_cmd) begin
            resel = |HWDATA[2:0];
            if (HWDATA[`SRH_CMD_RESET_BIT])
                resel_budget = `SRH_SEC_W'(`SRH_RESET_SYNC_S);
            else if (HWDATA[`SRH_CMD_START_BIT])
                resel_budget = `SRH_SEC_W'(`SRH_START_SYNC_S);
            else
                resel_budget = `SRH_SEC_W'(`SRH_WARM_SYNC_S);
        end
    end

    // register file next values; faults are set-wins write-one-to-clear
    always_comb begin
        enable_d   = enable_q;
        opt_pref_d = opt_pref_q;
        mode_d     = mode_q;
        stype_d    = stype_q;
        avail_a_d  = avail_a_q;
        avail_b_d  = avail_b_q;
        flt_clr    = '0;
        if (wr_ctrl) begin
            enable_d   = HWDATA[`SRH_CTRL_EN_BIT];
            opt_pref_d = HWDATA[`SRH_CTRL_OPT_BIT];
        end
        if (wr_cfg && cfg_ok) begin
            mode_d    = new_mode;
            stype_d   = new_stype;
            avail_a_d = HWDATA[`SRH_CFG_AVA_BIT];
            avail_b_d = HWDATA[`SRH_CFG_AVB_BIT];
        end
        if (wr_flt)
            flt_clr = HWDATA[`SRH_FLT_W-1:0];
        fault_d = (fault_q & ~flt_clr) | flt_set;
    end

    // main sequence: select, lock, synchronize, hold over
    always_comb begin
        state_d      = state_q;
        src_d        = src_q;
        exec_b_d     = exec_b_q;
        synced_d     = synced_q;
        miss_sent_d  = miss_sent_q;
        budget_d     = budget_q;
        budget_run_d = budget_run_q;
        flt_set      = '0;
        flt_set[`SRH_FLT_CFG_BIT] = wr_cfg && !cfg_ok;
        if (resel) begin
            budget_d     = resel_budget;
            budget_run_d = 1'b1;
        end
        if (budget_run_q && budget_secs >= budget_q && !resel) begin
            flt_set[`SRH_FLT_LATE_BIT] = 1'b1;
            budget_run_d = 1'b0;
        end
        // move off a defective PCM interface when the other is fit
        if (src_q == SRH_SRC_PCM && exec_defect && other_ok
            && state_q != SRH_IDLE && state_q != SRH_SELECT)
            exec_b_d = !exec_b_q;
        case (state_q)
            SRH_IDLE: begin
                synced_d = 1'b0;
                if (resel)
                    state_d = SRH_SELECT;
            end
            SRH_SELECT: begin
                // one cycle; stays only while no PCM interface is fit
                src_d = pick_src(mode_q, stype_q, OPT_FITTED, opt_pref_q);
                if (src_d != SRH_SRC_PCM) begin
                    state_d = SRH_LOCKING;
                end else if (pcm_ok(avail_a_q, PCM_A_DEFECT)) begin
                    exec_b_d = 1'b0;
                    state_d  = SRH_LOCKING;
                end else if (pcm_ok(avail_b_q, PCM_B_DEFECT)) begin
                    exec_b_d = 1'b1;
                    state_d  = SRH_LOCKING;
                end
            end
            SRH_LOCKING: begin
                if (resel) begin
                    state_d = SRH_SELECT;
                end else if (LOCK_DONE) begin
                    state_d      = SRH_SYNCING;
                    synced_d     = 1'b1;
                    budget_run_d = 1'b0;
                end else if (lock_secs >= `SRH_SEC_W'(`SRH_LOCK_TO_S)) begin
                    flt_set[`SRH_FLT_LOCK_BIT] = 1'b1;
                    state_d = SRH_SELECT;
                end
            end
            SRH_SYNCING: begin
                if (resel)
                    state_d = SRH_SELECT;
                else if (!REF_USABLE || CTRL_AT_LIMIT) begin
                    state_d     = SRH_HOLDOVER;
                    miss_sent_d = 1'b0;
                end
            end
            SRH_HOLDOVER: begin
                synced_d = 1'b1;
                if (hold_secs >= `SRH_SEC_W'(`SRH_HOLD_ENTER_S)
                    && !miss_sent_q) begin
                    flt_set[`SRH_FLT_MISS_BIT] = 1'b1;
                    miss_sent_d = 1'b1;
                end
                if (resel) begin
                    state_d = SRH_SELECT;
                end else if (REF_USABLE && !CTRL_AT_LIMIT) begin
                    state_d = SRH_SYNCING;
                end else if (hold_secs >= (mode_q == SRH_MODE_SLAVE
                         ? `SRH_SEC_W'(`SRH_HOLD_EXP_SL_S)
                         : `SRH_SEC_W'(`SRH_HOLD_EXP_MS_S))) begin
                    flt_set[`SRH_FLT_EXP_BIT] = 1'b1;
                    synced_d = 1'b0;
                    state_d  = SRH_SELECT;
                end
            end
            default: state_d = SRH_IDLE;
        endcase
        if (wr_ctrl && !HWDATA[`SRH_CTRL_EN_BIT]) begin
            state_d      = SRH_IDLE;
            synced_d     = 1'b0;
            budget_run_d = 1'b0;
        end
    end

    // all state freezes while CE is low, the bus slave included
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_q         <= 1'b0;
            waddr_q      <= 8'h00;
            rdata_q      <= 32'h0;
            enable_q     <= 1'b0;
            opt_pref_q   <= `SRH_CTRL_OPT_RST;
            mode_q       <= SRH_MODE_ALONE;
            stype_q      <= SRH_ST_UNDEF;
            avail_a_q    <= 1'b0;
            avail_b_q    <= 1'b0;
            fault_q      <= '0;
            state_q      <= SRH_IDLE;
            src_q        <= SRH_SRC_PCM;
            exec_b_q     <= 1'b0;
            synced_q     <= 1'b0;
            miss_sent_q  <= 1'b0;
            budget_q     <= '0;
            budget_run_q <= 1'b0;
        end else if (CE) begin
            wr_q         <= wr_d;
            waddr_q      <= waddr_d;
            rdata_q      <= rdata_d;
            enable_q     <= enable_d;
            opt_pref_q   <= opt_pref_d;
            mode_q       <= mode_d;
            stype_q      <= stype_d;
            avail_a_q    <= avail_a_d;
            avail_b_q    <= avail_b_d;
            fault_q      <= fault_d;
            state_q      <= state_d;
            src_q        <= src_d;
            exec_b_q     <= exec_b_d;
            synced_q     <= synced_d;
            miss_sent_q  <= miss_sent_d;
            budget_q     <= budget_d;
            budget_run_q <= budget_run_d;
        end
    end

    // the loop keeps its control value through selection and hold-over,
    // so a source change never steps phase or frequency of the one
    // oscillator that clocks RF and timebase alike
    assign OSC_HOLD   = (state_q == SRH_HOLDOVER)
                     || (state_q == SRH_SELECT);
    assign SRC_SEL    = src_q;
    assign PCM_EXEC_B = exec_b_q;
    assign SYNCED     = synced_q;
    assign HRDATA     = rdata_q;
    assign HREADYOUT  = 1'b1;
    assign HRESP      = 1'b0;

endmodule // srh_core

// ### test/srh_core_asserts.sv
// srh_core_asserts.sv: port-level checks of the hold-over controller.
// assumes: bound into srh_core; CE is held high by the bench.
`timescale 1ns/100ps
module srh_core_asserts #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic       CLK,
    input wire logic       ARST_N,
    input wire logic       CE,
    input wire logic       HREADYOUT,
    input wire logic       HRESP,
    input wire logic       PCM_B_DEFECT,
    input wire logic       REF_USABLE,
    input wire logic       CTRL_AT_LIMIT,
    input wire logic [1:0] SRC_SEL,
    input wire logic       PCM_EXEC_B,
    input wire logic       OSC_HOLD,
    input wire logic       SYNCED
);
    localparam int HOLD_MAX = 3600 * TICK_CYCLES + 8;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    // length of the present hold-over; a frozen clock must not count
    always_comb begin
        hold_d = OSC_HOLD ? (CE ? hold_q + 16'h0001 : hold_q) : 16'h0000;
    end
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            hold_q <= 16'h0000;
        end else begin
            hold_q <= hold_d;
        end
    end
    a_ready_high: assert property (HREADYOUT)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!HRESP)
        else $error("slave gave an error response");
    a_hold_synced: assert property (
        OSC_HOLD && $past(OSC_HOLD) |-> SYNCED || $fell(SYNCED))
        else $error("hold-over not reported synced");
    // selection also freezes the loop; only entry from sync needs a cause
    a_hold_cause: assert property (
        $rose(OSC_HOLD) && SYNCED
        |-> !$past(REF_USABLE) || $past(CTRL_AT_LIMIT))
        else $error("hold-over entered with a good reference");
    a_hold_exit: assert property (
        CE && OSC_HOLD && REF_USABLE && !CTRL_AT_LIMIT |=> !OSC_HOLD)
        else $error("hold-over kept with a usable reference");
    a_hold_bound: assert property (
        hold_q <= HOLD_MAX) else $error("hold-over outlived expiry");
    a_exec_b_free: assert property (
        $rose(PCM_EXEC_B) |-> !$past(PCM_B_DEFECT))
        else $error("moved to a faulty interface");
    a_src_legal: assert property (
        SRC_SEL != 2'h3) else $error("undefined source selected");
    c_hold: cover property ($rose(OSC_HOLD));
    c_expiry: cover property ($fell(SYNCED) && $past(OSC_HOLD));
    c_exec_b: cover property ($rose(PCM_EXEC_B));
endmodule // srh_core_asserts

bind srh_core srh_core_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .CLK(CLK), .ARST_N(ARST_N), .CE(CE), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .PCM_B_DEFECT(PCM_B_DEFECT), .REF_USABLE(REF_USABLE),
    .CTRL_AT_LIMIT(CTRL_AT_LIMIT), .SRC_SEL(SRC_SEL),
    .PCM_EXEC_B(PCM_EXEC_B), .OSC_HOLD(OSC_HOLD), .SYNCED(SYNCED));

// ### test/srh_ref_model.sv
// srh_ref_model.sv: timing sources: line alarms, supervision verdict
// and a loop that claims lock after a steady request.
// assumes: the bench steers each source through the plain inputs.
`timescale 1ns/100ps
module srh_ref_model (
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       LOCK_EN,
    input  wire logic [3:0] LOCK_DLY,
    input  wire logic       USABLE,
    input  wire logic [1:0] DEFECT,
    output logic            REF_USABLE,
    output logic            LOCK_DONE,
    output logic            PCM_A_DEFECT,
    output logic            PCM_B_DEFECT,
    output logic            CTRL_AT_LIMIT
);
    logic [3:0] cnt_q;
    // lock only after LOCK_DLY cycles, so slow and prompt loops both occur
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N || !LOCK_EN) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != LOCK_DLY) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    assign LOCK_DONE = LOCK_EN && (cnt_q == LOCK_DLY);
    // line alarms stand for loss of signal, frame or alarm indication
    assign PCM_A_DEFECT = DEFECT[0];
    assign PCM_B_DEFECT = DEFECT[1];
    assign REF_USABLE = USABLE;
    assign CTRL_AT_LIMIT = 1'h0;
endmodule // srh_ref_model

// ### test/sync_reference_holdover_tb_top.sv
// sync_reference_holdover_tb_top.sv: self-checking bench for srh_core.
// assumes: zero-wait slave; TICK cycles make one second.
`timescale 1ns/100ps
module sync_reference_holdover_tb_top;
    import srh_pkg::*;
    localparam int TICK = 4;
    logic        clk, arst_n, hsel, hwrite, hrdy, hresp, opt, usable;
    logic        lock_en, ref_ok, lock_done, def_a, def_b, at_lim;
    logic        exec_b, osc_hold, synced;
    logic [1:0]  htrans, defect, src_sel;
    logic [3:0]  dly;
    logic [31:0] haddr, hwdata, hrdata, r;
    int          errors, cmp_count, seed;
    int          cfgs[$] = '{32'h36, 32'h33, 32'h02};
    int          opts[$] = '{0, 0, 1};

    srh_ref_model u_ref (.CLK(clk), .ARST_N(arst_n), .LOCK_EN(lock_en),
        .LOCK_DLY(dly), .USABLE(usable), .DEFECT(defect),
        .REF_USABLE(ref_ok), .LOCK_DONE(lock_done), .PCM_A_DEFECT(def_a),
        .PCM_B_DEFECT(def_b), .CTRL_AT_LIMIT(at_lim));
    srh_core #(.TICK_CYCLES(TICK)) dut (.CLK(clk), .ARST_N(arst_n),
        .CE(1'h1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
        .PCM_A_DEFECT(def_a), .PCM_B_DEFECT(def_b), .OPT_FITTED(opt),
        .REF_USABLE(ref_ok), .LOCK_DONE(lock_done),
        .CTRL_AT_LIMIT(at_lim), .SRC_SEL(src_sel), .PCM_EXEC_B(exec_b),
        .OSC_HOLD(osc_hold), .SYNCED(synced));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; hready is awaited in both phases
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hrdy !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'h1);
        r = hrdata;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(r, e);
    endtask

    // source chosen from mode, source type and fitted hardware
    function automatic logic [1:0] exp_src(input int cfg, input int o);
        if ((cfg & 3) == 3) return SRH_SRC_PEER;
        if (((cfg >> 2) & 3) == 1 || o == 0) return SRH_SRC_PCM;
        return SRH_SRC_OPT;
    endfunction

    task complete_run;
        if (errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // a hang ends the run as a failure
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        complete_run;
    end

    initial begin
        seed = 5284;
        errors = 0;
        cmp_count = 0;
        {arst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {lock_en, usable, defect, opt, dly} = {1'h0, 1'h1, 2'h1, 1'h0, 4'h2};
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
        chk({26'h0, hresp, synced, osc_hold, exec_b, src_sel}, 32'h0);
        rdc(8'h04, 32'h2);
        rdc(8'h00, 32'h2);
        lock_en <= 1'h1;
        for (int i = 0; i < 3; i++) begin
            bus(1'h1, 8'h00, 32'h0);
            bus(1'h1, 8'h04, cfgs[i]);
            opt <= opts[i][0];
            dly <= 4'($random(seed));
            bus(1'h1, 8'h00, 32'h3);
            for (int k = 0; k < 200 && synced !== 1'h1; k++) @(posedge clk);
            chk({30'h0, src_sel}, {30'h0, exp_src(cfgs[i], opts[i])});
            if (i == 0) chk({31'h0, exec_b}, 32'h1);
        end
        bus(1'h1, 8'h04, 32'h3);
        rdc(8'h0C, 32'h8);
        rdc(8'h04, 32'h2);
        bus(1'h1, 8'h0C, 32'h1F);
        for (int n = 0; n < 2; n++) begin
            usable <= 1'h0;
            lock_en <= 1'h0;
            for (int k = 0; k < 20 && osc_hold !== 1'h1; k++) @(posedge clk);
            chk({31'h0, synced}, 32'h1);
            if (n == 0) begin
                usable <= 1'h1;
                repeat (3) @(posedge clk);
                chk({31'h0, osc_hold}, 32'h0);
            end
        end
        repeat (300 * TICK - 14) @(posedge clk);
        rdc(8'h0C, 32'h0);
        repeat (24) @(posedge clk);
        rdc(8'h0C, 32'h1);
        repeat (3300 * TICK - 28) @(posedge clk);
        chk({31'h0, synced}, 32'h1);
        repeat (24) @(posedge clk);
        chk({30'h0, synced, osc_hold}, 32'h0);
        rdc(8'h0C, 32'h3);
        bus(1'h1, 8'h00, 32'h0);
        bus(1'h1, 8'h0C, 32'h1F);
        opt <= 1'h0;
        bus(1'h1, 8'h04, 32'h3A);
        rdc(8'h0C, 32'h8);
        rdc(8'h04, 32'h2);
        bus(1'h1, 8'h20, $random(seed));
        rdc(8'h20, 32'h0);
        complete_run;
    end
endmodule // sync_reference_holdover_tb_top
